// >>> verilog/slope_route_interval_gen.sv
// Slope selection, signal routing and interval generation for a counter front end.
//
// Functional notes
// - Each channel is inverted when its slope control is high.
// - Each slope selector also gives its complemented output.
// - Each slope-adjusted signal drives its own monitor output.
// - Interval functions block both direct gates and feed the generator.
// - Manual timing blocks both direct routing gates.
// - Totalize and frequency block channel two direct gate, keep channel one.
// - Reset drives interval low and complement high, awaiting channel one.
// - First channel one edge sets interval high, then awaits channel two.
// - Channel two edge while high returns generator to reset state.
// - One pulse per cycle, rising on channel one, falling on channel two.
// - Independent polarity lets either edge of each channel bound the interval.
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module slope_route_interval_gen
    import slope_route_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        channel_one_input,
    input  wire logic        channel_two_input,
    input  wire logic        gen_reset_in,
    output logic             shaped_monitor_out_one,
    output logic             shaped_monitor_out_two,
    output logic             route_one,
    output logic             route_two,
    output logic             interval_out,
    output logic             interval_out_n,
    output logic             slope_one_n,
    output logic             slope_two_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    typedef struct packed {
        logic [1:0]        sync_one;
        logic [1:0]        sync_two;
        logic              prev_one;
        logic              prev_two;
        logic              slope_one;
        logic              slope_two;
        logic              soft_reset;
        logic [FUNC_W-1:0] func;
        logic              wr_pend;
        logic [7:0]        addr;
        logic [15:0]       count;
        logic              mon_one;
        logic              mon_two;
        logic              mon_one_n;
        logic              mon_two_n;
        logic              r_one;
        logic              r_two;
        logic              g_one;
        logic              g_two;
        logic              ival;
        logic              ival_n;
        logic [31:0]       rdata;
    } top_reg_t;

    top_reg_t cur;
    top_reg_t next_cur;

    interval_link_if link ();

    interval_gen u_gen (
        .core_clk (core_clk),
        .srst     (srst),
        .link     (link.generator)
    );

    logic adj_one;
    logic adj_two;
    logic interval_func;
    logic block_both;
    logic block_two;
    logic [31:0] status_word;
    logic [31:0] control_word;

    always_comb begin
        adj_one = cur.sync_one[1] ^ cur.slope_one;
        adj_two = cur.sync_two[1] ^ cur.slope_two;

        interval_func = (cur.func == FUNC_INTERVAL_VAR) || (cur.func == FUNC_INTERVAL_AVG);
        block_both = interval_func || (cur.func == FUNC_MANUAL);
        block_two = block_both || (cur.func == FUNC_TOTALIZE) || (cur.func == FUNC_FREQUENCY);

        control_word = 32'h0000_0000;
        control_word[CTL_SLOPE_ONE] = cur.slope_one;
        control_word[CTL_SLOPE_TWO] = cur.slope_two;
        control_word[CTL_FUNC_LSB +: FUNC_W] = cur.func;

        status_word = 32'h0000_0000;
        status_word[STA_INTERVAL]  = link.interval;
        status_word[STA_ROUTE_ONE] = cur.r_one;
        status_word[STA_ROUTE_TWO] = cur.r_two;
        status_word[STA_GEN_ONE]   = cur.g_one;
        status_word[STA_GEN_TWO]   = cur.g_two;
        status_word[STA_MON_ONE]   = cur.mon_one;
        status_word[STA_MON_TWO]   = cur.mon_two;
    end

    assign link.edge_one  = interval_func && adj_one && !cur.prev_one;
    assign link.edge_two  = interval_func && adj_two && !cur.prev_two;
    // The generator is held cleared outside interval functions.
    assign link.gen_reset = gen_reset_in || cur.soft_reset || !interval_func;

    always_comb begin
        next_cur = cur;
        next_cur.sync_one = {cur.sync_one[0], channel_one_input};
        next_cur.sync_two = {cur.sync_two[0], channel_two_input};
        next_cur.prev_one = adj_one;
        next_cur.prev_two = adj_two;

        next_cur.mon_one = adj_one;
        next_cur.mon_two = adj_two;
        next_cur.mon_one_n = !adj_one;
        next_cur.mon_two_n = !adj_two;

        next_cur.r_one = block_both ? 1'b0 : adj_one;
        next_cur.r_two = block_two ? 1'b0 : adj_two;
        next_cur.g_one = interval_func ? adj_one : 1'b0;
        next_cur.g_two = interval_func ? adj_two : 1'b0;
        next_cur.ival   = link.interval;
        next_cur.ival_n = link.interval_n;

        if (link.edge_one && !link.gen_reset && !link.interval) begin
            next_cur.count = cur.count + 16'h0001;
        end

        next_cur.soft_reset = 1'b0;
        next_cur.wr_pend    = 1'b0;
        if (cur.wr_pend) begin
            if (cur.addr == OFS_CONTROL) begin
                next_cur.slope_one  = hwdata[CTL_SLOPE_ONE];
                next_cur.slope_two  = hwdata[CTL_SLOPE_TWO];
                next_cur.soft_reset = hwdata[CTL_GEN_RESET];
                next_cur.func       = hwdata[CTL_FUNC_LSB +: FUNC_W];
            end else if (cur.addr == OFS_COUNT) begin
                next_cur.count = 16'h0000;
            end
        end
        // Read data is taken in the address phase; a write landing in that same
        // cycle is not yet visible to a back-to-back read.
        if (hsel && hready && htrans == HTRANS_NONSEQ) begin
            next_cur.addr    = haddr[7:0];
            next_cur.wr_pend = hwrite;
            case (haddr[7:0])
                OFS_CONTROL: next_cur.rdata = control_word;
                OFS_STATUS:  next_cur.rdata = status_word;
                OFS_COUNT:   next_cur.rdata = {16'h0000, cur.count};
                default:     next_cur.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
            cur.func   <= RST_FUNCTION;
            cur.ival_n <= 1'b1;
            cur.mon_one_n <= 1'b1;
            cur.mon_two_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign shaped_monitor_out_one = cur.mon_one;
    assign shaped_monitor_out_two = cur.mon_two;
    assign slope_one_n    = cur.mon_one_n;
    assign slope_two_n    = cur.mon_two_n;
    assign route_one      = cur.r_one;
    assign route_two      = cur.r_two;
    assign interval_out   = cur.ival;
    assign interval_out_n = cur.ival_n;
    assign hrdata         = cur.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;

    property p_inv;
        @(posedge core_clk) disable iff (srst)
        ##1 shaped_monitor_out_one == ($past(cur.sync_one[1]) ^ $past(cur.slope_one));
    endproperty
    a_inv: assert property (p_inv) else $error("slope selection wrong");

    property p_comp;
        @(posedge core_clk) disable iff (srst)
        slope_two_n == !shaped_monitor_out_two;
    endproperty
    a_comp: assert property (p_comp) else $error("complement wrong");

    property p_mon;
        @(posedge core_clk) disable iff (srst)
        ##1 shaped_monitor_out_two == $past(adj_two);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor wrong");

    property p_intblock;
        @(posedge core_clk) disable iff (srst)
        interval_func |=> (!route_one && !route_two);
    endproperty
    a_intblock: assert property (p_intblock) else $error("interval gates open");

    property p_manual;
        @(posedge core_clk) disable iff (srst)
        (cur.func == FUNC_MANUAL) |=> (!route_one && !route_two);
    endproperty
    a_manual: assert property (p_manual) else $error("manual gates open");

    property p_tot;
        @(posedge core_clk) disable iff (srst)
        (cur.func == FUNC_TOTALIZE || cur.func == FUNC_FREQUENCY)
            |=> (!route_two && route_one == $past(adj_one));
    endproperty
    a_tot: assert property (p_tot) else $error("totalize routing wrong");

    sequence s_open_seen;
        link.interval ##1 interval_out;
    endsequence
    property p_edge;
        @(posedge core_clk) disable iff (srst)
        (interval_func && !link.gen_reset && !link.interval && adj_one && !cur.prev_one)
            |=> s_open_seen;
    endproperty
    a_edge: assert property (p_edge) else $error("edge not seen");

    property p_sync_one;
        @(posedge core_clk) disable iff (srst)
        ##2 cur.sync_one[1] == $past(channel_one_input, 2);
    endproperty
    a_sync_one: assert property (p_sync_one) else $error("sync one late");

    property p_sync_two;
        @(posedge core_clk) disable iff (srst)
        ##2 cur.sync_two[1] == $past(channel_two_input, 2);
    endproperty
    a_sync_two: assert property (p_sync_two) else $error("sync two late");

    property p_slope_two;
        @(posedge core_clk) disable iff (srst)
        ##1 shaped_monitor_out_two == ($past(cur.sync_two[1]) ^ $past(cur.slope_two));
    endproperty
    a_slope_two: assert property (p_slope_two) else $error("slope two wrong");

    property p_comp_one;
        @(posedge core_clk) disable iff (srst)
        slope_one_n == !shaped_monitor_out_one;
    endproperty
    a_comp_one: assert property (p_comp_one) else $error("complement one wrong");

    property p_mon_one;
        @(posedge core_clk) disable iff (srst)
        ##1 shaped_monitor_out_one == $past(adj_one);
    endproperty
    a_mon_one: assert property (p_mon_one) else $error("monitor one wrong");

    property p_one_open;
        @(posedge core_clk) disable iff (srst)
        !block_both |=> (route_one == $past(adj_one));
    endproperty
    a_one_open: assert property (p_one_open) else $error("channel one gate shut");

    property p_two_open;
        @(posedge core_clk) disable iff (srst)
        !block_two |=> (route_two == $past(adj_two));
    endproperty
    a_two_open: assert property (p_two_open) else $error("channel two gate shut");

    property p_gen_feed;
        @(posedge core_clk) disable iff (srst)
        interval_func |=> (cur.g_one == $past(adj_one) && cur.g_two == $past(adj_two));
    endproperty
    a_gen_feed: assert property (p_gen_feed) else $error("generator not fed");

    property p_gen_idle;
        @(posedge core_clk) disable iff (srst)
        !interval_func |=> (!cur.g_one && !cur.g_two && !link.interval);
    endproperty
    a_gen_idle: assert property (p_gen_idle) else $error("generator fed when blocked");

    property p_ext_reset;
        @(posedge core_clk) disable iff (srst)
        gen_reset_in |=> (!link.interval && link.interval_n);
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("reset input ignored");

    property p_soft_reset;
        @(posedge core_clk) disable iff (srst)
        cur.soft_reset |=> !link.interval;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset ignored");

    property p_count_up;
        @(posedge core_clk) disable iff (srst)
        (link.edge_one && !link.gen_reset && !link.interval
            && !(cur.wr_pend && cur.addr == OFS_COUNT))
            |=> (cur.count == $past(cur.count) + 16'h0001);
    endproperty
    a_count_up: assert property (p_count_up) else $error("interval not counted");

    property p_count_clear;
        @(posedge core_clk) disable iff (srst)
        (cur.wr_pend && cur.addr == OFS_COUNT) |=> (cur.count == 16'h0000);
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared");

    property p_out_follow;
        @(posedge core_clk) disable iff (srst)
        ##1 (interval_out == $past(link.interval) && interval_out_n == $past(link.interval_n));
    endproperty
    a_out_follow: assert property (p_out_follow) else $error("interval output lags");

    property p_rise_cause;
        @(posedge core_clk) disable iff (srst)
        $rose(link.interval) |-> $past(link.edge_one && !link.gen_reset);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("interval rose unasked");

    property p_fall_cause;
        @(posedge core_clk) disable iff (srst)
        $fell(link.interval) |-> $past(link.edge_two || link.gen_reset || srst);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("interval fell unasked");

endmodule

// >>> verilog/slope_route_pkg.sv
// Package with constants and types shared by the slope, routing and interval logic.
package slope_route_pkg;

    // Measurement function codes held in the function register.
    localparam logic [3:0] FUNC_FREQUENCY      = 4'h0;
    localparam logic [3:0] FUNC_PERIOD         = 4'h1;
    localparam logic [3:0] FUNC_WIDTH          = 4'h2;
    localparam logic [3:0] FUNC_INTERVAL_VAR   = 4'h3;
    localparam logic [3:0] FUNC_PERIOD_AVG     = 4'h4;
    localparam logic [3:0] FUNC_WIDTH_AVG      = 4'h5;
    localparam logic [3:0] FUNC_INTERVAL_AVG   = 4'h6;
    localparam logic [3:0] FUNC_EVENTS_DURING  = 4'h7;
    localparam logic [3:0] FUNC_RATIO          = 4'h8;
    localparam logic [3:0] FUNC_TOTALIZE       = 4'h9;
    localparam logic [3:0] FUNC_MANUAL         = 4'hA;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_COUNT   = 8'h08;

    // Control register fields.
    localparam int CTL_SLOPE_ONE = 0;
    localparam int CTL_SLOPE_TWO = 1;
    localparam int CTL_GEN_RESET = 2;
    localparam int CTL_FUNC_LSB  = 4;
    localparam int FUNC_W        = 4;

    // Status register fields.
    localparam int STA_INTERVAL  = 0;
    localparam int STA_ROUTE_ONE = 1;
    localparam int STA_ROUTE_TWO = 2;
    localparam int STA_GEN_ONE   = 3;
    localparam int STA_GEN_TWO   = 4;
    localparam int STA_MON_ONE   = 5;
    localparam int STA_MON_TWO   = 6;

    localparam logic [3:0] RST_FUNCTION = FUNC_FREQUENCY;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic {GEN_WAIT_ONE, GEN_WAIT_TWO} gen_state_t;

endpackage

// >>> verilog/interval_link_if.sv
// Interface joining the router to the interval generator.
`timescale 1ns/1ps
interface interval_link_if;
    logic edge_one;
    logic edge_two;
    logic gen_reset;
    logic interval;
    logic interval_n;

    modport router (output edge_one, output edge_two, output gen_reset,
                    input interval, input interval_n);
    modport generator (input edge_one, input edge_two, input gen_reset,
                       output interval, output interval_n);
endinterface

// >>> verilog/interval_gen.sv
// Interval generator: pulse from a channel one edge to the next channel two edge.
`timescale 1ns/1ps
module interval_gen
    import slope_route_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   srst,
    interval_link_if.generator link
);

    typedef struct packed {
        gen_state_t state;
        logic       interval;
        logic       interval_n;
    } gen_reg_t;

    gen_reg_t cur;
    gen_reg_t next_cur;

    always_comb begin
        next_cur = cur;
        if (link.gen_reset) begin
            next_cur.state      = GEN_WAIT_ONE;
            next_cur.interval   = 1'b0;
            next_cur.interval_n = 1'b1;
        end else begin
            case (cur.state)
                GEN_WAIT_ONE: begin
                    if (link.edge_one) begin
                        next_cur.state      = GEN_WAIT_TWO;
                        next_cur.interval   = 1'b1;
                        next_cur.interval_n = 1'b0;
                    end
                end
                GEN_WAIT_TWO: begin
                    if (link.edge_two) begin
                        next_cur.state      = GEN_WAIT_ONE;
                        next_cur.interval   = 1'b0;
                        next_cur.interval_n = 1'b1;
                    end
                end
                default: begin
                    next_cur.state = GEN_WAIT_ONE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur.state      <= GEN_WAIT_ONE;
            cur.interval   <= 1'b0;
            cur.interval_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign link.interval   = cur.interval;
    assign link.interval_n = cur.interval_n;

    property p_open;
        @(posedge core_clk) disable iff (srst)
        (!link.gen_reset && !cur.interval && link.edge_one) |=> (cur.interval && !cur.interval_n);
    endproperty
    a_open: assert property (p_open) else $error("interval did not open");

    property p_close;
        @(posedge core_clk) disable iff (srst)
        (!link.gen_reset && cur.interval && link.edge_two) |=> (!cur.interval && cur.interval_n);
    endproperty
    a_close: assert property (p_close) else $error("interval did not close");

    property p_hold;
        @(posedge core_clk) disable iff (srst)
        (!link.gen_reset && cur.interval && !link.edge_two) |=> cur.interval;
    endproperty
    a_hold: assert property (p_hold) else $error("interval fell early");

    property p_reset;
        @(posedge core_clk) disable iff (srst)
        link.gen_reset |=> (!cur.interval && cur.interval_n);
    endproperty
    a_reset: assert property (p_reset) else $error("generator reset ignored");

    property p_compl;
        @(posedge core_clk) disable iff (srst)
        cur.interval_n == !cur.interval;
    endproperty
    a_compl: assert property (p_compl) else $error("complement mismatch");

endmodule

// >>> test/gate_accum_model.sv
// Far-side model of the gate generator, which counts the interval gates it receives.
`timescale 1ns/1ps
module gate_accum_model (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic interval_out,
    output int        gate_count
);
    logic ival_d;

    // Each rising edge of the interval output opens one measurement gate.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ival_d     <= 1'b0;
            gate_count <= 0;
        end else begin
            ival_d <= interval_out;
            if (interval_out && !ival_d) begin
                gate_count <= gate_count + 1;
            end
        end
    end
endmodule

// >>> test/slope_route_interval_gen_tb.sv
// Self-checking bench for slope selection, routing and interval generation.
`timescale 1ns/1ps
module slope_route_interval_gen_tb;
    import slope_route_pkg::*;
    logic        core_clk, srst, ch_one, ch_two, gen_rst, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire         hready_w;
    logic        hresp, mon_one, mon_two, rt_one, rt_two, ival, ival_n, sl_one_n, sl_two_n;
    int          failures, n_compared, gate_count, base, model_cnt;

    slope_route_interval_gen dut (
        .core_clk(core_clk), .srst(srst), .channel_one_input(ch_one),
        .channel_two_input(ch_two), .gen_reset_in(gen_rst),
        .shaped_monitor_out_one(mon_one), .shaped_monitor_out_two(mon_two),
        .route_one(rt_one), .route_two(rt_two), .interval_out(ival), .interval_out_n(ival_n),
        .slope_one_n(sl_one_n), .slope_two_n(sl_two_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready_w), .hrdata(hrdata), .hreadyout(hready_w), .hresp(hresp)
    );

    gate_accum_model partner (
        .core_clk(core_clk), .srst(srst), .interval_out(ival), .gate_count(gate_count)
    );

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hready_w !== 1'b1 && k < 100);
        if (hready_w !== 1'b1) begin
            $display("[FAIL] hready expected 1 seen %b", hready_w);
            failures++;
            tally_and_finish();
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask

    task automatic ctl(input logic [3:0] f, input logic [1:0] s);
        ahb(1'b1, 32'(OFS_CONTROL), (32'(f) << CTL_FUNC_LSB) | 32'(s), rdata);
    endtask

    task automatic set_in(input logic a, input logic b);
        @(posedge core_clk);
        ch_one <= a;
        ch_two <= b;
        repeat (6) @(posedge core_clk);
        #1;
    endtask

    task automatic chk_iv(input logic e);
        chk("interval", 32'(e), 32'(ival));
        chk("interval complement", 32'(!e), 32'(ival_n));
    endtask

    task automatic chk_out(input logic [3:0] f, input logic [1:0] s);
        logic adj1, adj2, blk1, blk2;
        adj1 = ch_one ^ s[0];
        adj2 = ch_two ^ s[1];
        blk1 = (f == FUNC_INTERVAL_VAR || f == FUNC_INTERVAL_AVG || f == FUNC_MANUAL);
        blk2 = blk1 || f == FUNC_FREQUENCY || f == FUNC_TOTALIZE;
        chk("monitor one", 32'(adj1), 32'(mon_one));
        chk("monitor two", 32'(adj2), 32'(mon_two));
        chk("slope one n", 32'(!adj1), 32'(sl_one_n));
        chk("slope two n", 32'(!adj2), 32'(sl_two_n));
        chk("route one", 32'(blk1 ? 1'b0 : adj1), 32'(rt_one));
        chk("route two", 32'(blk2 ? 1'b0 : adj2), 32'(rt_two));
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        logic [3:0] funcs [6];
        logic [3:0] f;
        logic [1:0] s;
        funcs = '{FUNC_FREQUENCY, FUNC_TOTALIZE, FUNC_MANUAL, FUNC_INTERVAL_VAR,
                  FUNC_INTERVAL_AVG, FUNC_PERIOD};
        failures = 0;
        n_compared = 0;
        model_cnt = 0;
        srst = 1'b1;
        {ch_one, ch_two, gen_rst, hsel, hwrite} = 5'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        void'($urandom(47));
        repeat (20) @(posedge core_clk);
        #1;
        chk_iv(1'b0);
        chk("slope n at reset", 32'h3, 32'({sl_one_n, sl_two_n}));
        @(posedge core_clk);
        srst <= 1'b0;
        for (int fi = 0; fi < 6; fi++) begin
            for (int si = 0; si < 4; si++) begin
                ctl(funcs[fi], 2'(si));
                repeat (3) begin
                    set_in(1'($urandom), 1'($urandom));
                    chk_out(funcs[fi], 2'(si));
                end
            end
        end
        $display("test routing done");
        ahb(1'b1, 32'(OFS_COUNT), 32'h0, rdata);
        ahb(1'b0, 32'(OFS_COUNT), 32'h0, rdata);
        chk("count cleared", 32'h0, rdata);
        base = gate_count;
        for (int si = 0; si < 4; si++) begin
            s = 2'(si);
            f = s[0] ? FUNC_INTERVAL_AVG : FUNC_INTERVAL_VAR;
            ctl(FUNC_FREQUENCY, s);
            set_in(s[0], s[1]);
            ctl(f, s);
            set_in(s[0], s[1]);
            chk_iv(1'b0);
            set_in(s[0], ~s[1]);
            chk_iv(1'b0);
            set_in(s[0], s[1]);
            set_in(~s[0], s[1]);
            model_cnt++;
            chk_iv(1'b1);
            ahb(1'b0, 32'(OFS_STATUS), 32'h0, rdata);
            chk("status interval", 32'h1, 32'(rdata[STA_INTERVAL]));
            set_in(s[0], s[1]);
            set_in(~s[0], s[1]);
            chk_iv(1'b1);
            set_in(s[0], ~s[1]);
            chk_iv(1'b0);
        end
        ahb(1'b0, 32'(OFS_COUNT), 32'h0, rdata);
        chk("interval count", 32'(model_cnt), rdata);
        chk("gates seen", 32'(model_cnt), 32'(gate_count - base));
        $display("test interval done");
        ctl(FUNC_INTERVAL_VAR, 2'h0);
        set_in(1'b0, 1'b0);
        @(posedge core_clk);
        gen_rst <= 1'b1;
        set_in(1'b1, 1'b0);
        chk_iv(1'b0);
        @(posedge core_clk);
        gen_rst <= 1'b0;
        set_in(1'b0, 1'b0);
        set_in(1'b1, 1'b0);
        chk_iv(1'b1);
        ahb(1'b1, 32'(OFS_CONTROL),
            (32'(FUNC_INTERVAL_VAR) << CTL_FUNC_LSB) | (32'h1 << CTL_GEN_RESET), rdata);
        set_in(1'b1, 1'b0);
        chk_iv(1'b0);
        ahb(1'b0, 32'h0000000C, 32'h0, rdata);
        chk("unmapped read", 32'h0, rdata);
        chk("response", 32'h0, 32'(hresp));
        $display("test reset and bus done");
        tally_and_finish();
    end
endmodule
